/* src/bfiu_alu.v */
`timescale 1ns/1ps
`include "bfiu_map.vh"
module bfiu_alu (
  // Operation select and operands.
  input wire [4:0] opCode,
  input wire [2:0] bitSel,
  input wire [7:0] operand,
  input wire [7:0] flagsIn,
  // Results.
  output reg [7:0] result,
  output reg [7:0] flagsOut,
  output reg writesResult
);
  reg [7:0] r;
  reg [7:0] f;
  reg [7:0] mask;
  // Combinational datapath computing result and new flags.
  always @* begin
    r = operand;
    f = flagsIn;
    mask = 8'h01 << bitSel;
    writesResult = 1'b1;
    case (opCode)
      `BFIU_OP_ROTATE_LEFT_CARRY: begin
        r = {operand[6:0], flagsIn[`BFIU_C_BIT]};
        f[`BFIU_C_BIT] = operand[7];
        f[`BFIU_H_BIT] = operand[3];
      end
      `BFIU_OP_ROTATE_RIGHT_CARRY: begin
        r = {flagsIn[`BFIU_C_BIT], operand[7:1]};
        f[`BFIU_C_BIT] = operand[0];
      end
      `BFIU_OP_ARITH_SHIFT_RIGHT: begin
        r = {operand[7], operand[7:1]};
        f[`BFIU_C_BIT] = operand[0];
      end
      `BFIU_OP_SWAP: r = {operand[3:0], operand[7:4]};
      `BFIU_OP_IOSET: r = operand | mask;
      `BFIU_OP_IOCLR: r = operand & ~mask;
      `BFIU_OP_BIT_TO_TRANSFER_FLAG: begin
        f[`BFIU_T_BIT] = operand[bitSel];
        writesResult = 1'b0;
      end
      `BFIU_OP_TRANSFER_FLAG_TO_BIT: begin
        if (flagsIn[`BFIU_T_BIT]) begin
          r = operand | mask;
        end else begin
          r = operand & ~mask;
        end
      end
      // Single-flag set; bitSel picks the flag.
      `BFIU_OP_FSET: begin
        f = flagsIn | mask;
        writesResult = 1'b0;
      end
      `BFIU_OP_FCLR: begin
        f = flagsIn & ~mask;
        writesResult = 1'b0;
      end
      default: writesResult = 1'b0;
    endcase
    // Shift and rotate update Z, N, V and S from the result.
    if (opCode == `BFIU_OP_ROTATE_LEFT_CARRY ||
        opCode == `BFIU_OP_ROTATE_RIGHT_CARRY ||
        opCode == `BFIU_OP_ARITH_SHIFT_RIGHT) begin
      f[`BFIU_Z_BIT] = (r == 8'h00);
      f[`BFIU_N_BIT] = r[7];
      f[`BFIU_V_BIT] = r[7] ^ f[`BFIU_C_BIT];
      f[`BFIU_S_BIT] = r[7] ^ f[`BFIU_V_BIT];
    end
    result = r;
    flagsOut = f;
  end
endmodule // bfiu_alu

/* src/bfiu_map.vh */
`ifndef BFIU_MAP_VH
`define BFIU_MAP_VH
// AXI4-Lite register byte offsets.
`define BFIU_CTRL_OFS 4'h0
`define BFIU_OPERAND_OFS 4'h4
`define BFIU_RESULT_OFS 4'h8
`define BFIU_FLAGS_OFS 4'hc
// Status flag bit positions.
`define BFIU_C_BIT 0
`define BFIU_Z_BIT 1
`define BFIU_N_BIT 2
`define BFIU_V_BIT 3
`define BFIU_S_BIT 4
`define BFIU_H_BIT 5
`define BFIU_T_BIT 6
`define BFIU_I_BIT 7
// Operation codes, written to the low bits of the control register.
`define BFIU_OP_NOP 5'h00
`define BFIU_OP_ROTATE_LEFT_CARRY 5'h01
`define BFIU_OP_ROTATE_RIGHT_CARRY 5'h02
`define BFIU_OP_ARITH_SHIFT_RIGHT 5'h03
`define BFIU_OP_SWAP 5'h04
`define BFIU_OP_IOSET 5'h05
`define BFIU_OP_IOCLR 5'h06
`define BFIU_OP_BIT_TO_TRANSFER_FLAG 5'h07
`define BFIU_OP_TRANSFER_FLAG_TO_BIT 5'h08
`define BFIU_OP_FSET 5'h09
`define BFIU_OP_FCLR 5'h0a
// Reset values.
`define BFIU_FLAGS_RST 8'h00
`define BFIU_DATA_RST 8'h00
// Execution takes one clock.
`define BFIU_EXEC_CYCLES 1
`endif

/* src/bfiu_top.v */
`timescale 1ns/1ps
`include "bfiu_map.vh"
module bfiu_top (
  // Clock and reset.
  input wire ref_clk,
  input wire rst,
  // AXI4-Lite write address.
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data.
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response.
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address.
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data.
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Live status flags.
  output reg [7:0] statusFlags
);
  localparam [1:0] RESP_OKAY = 2'b00;
  localparam [1:0] RESP_SLVERR = 2'b10;
  reg [3:0] awAddr_r;
  reg awHeld_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  reg wHeld_r;
  reg [7:0] ctrl_r;
  reg [7:0] operand_r;
  reg [7:0] result_r;
  reg execGo_r;
  wire [7:0] aluResult;
  wire [7:0] aluFlags;
  wire aluWrites;
  wire doWrite;
  // A write commits once both halves are held and no response waits.
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

  bfiu_alu u_alu (
    .opCode(ctrl_r[4:0]),
    .bitSel(ctrl_r[7:5]),
    .operand(operand_r),
    .flagsIn(statusFlags),
    .result(aluResult),
    .flagsOut(aluFlags),
    .writesResult(aluWrites)
  );

  // Address and data channels are captured independently.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 4'h0;
      s_axi_awready <= 1'b0;
      wHeld_r <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld_r && !s_axi_awready;
      s_axi_wready <= !wHeld_r && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // Register writes, response, and one-clock execution.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= 8'h00;
      operand_r <= `BFIU_DATA_RST;
      result_r <= `BFIU_DATA_RST;
      statusFlags <= `BFIU_FLAGS_RST;
      execGo_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      execGo_r <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Execution retires in the cycle after the control write.
      if (execGo_r) begin
        statusFlags <= aluFlags;
        if (aluWrites) begin
          result_r <= aluResult;
        end
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OKAY;
        case (awAddr_r)
          `BFIU_CTRL_OFS: begin
            if (wStrb_r[0]) begin
              ctrl_r <= wData_r[7:0];
              execGo_r <= 1'b1;
            end
          end
          `BFIU_OPERAND_OFS: begin
            if (wStrb_r[0]) begin
              operand_r <= wData_r[7:0];
            end
          end
          `BFIU_FLAGS_OFS: begin
            if (wStrb_r[0] && !execGo_r) begin
              statusFlags <= wData_r[7:0];
            end
          end
          `BFIU_RESULT_OFS: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end
    end
  end

  // Read channel: one read at a time, answered a cycle after acceptance.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          `BFIU_CTRL_OFS: s_axi_rdata <= {24'h000000, ctrl_r};
          `BFIU_OPERAND_OFS: s_axi_rdata <= {24'h000000, operand_r};
          `BFIU_RESULT_OFS: s_axi_rdata <= {24'h000000, result_r};
          `BFIU_FLAGS_OFS: s_axi_rdata <= {24'h000000, statusFlags};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // bfiu_top

/* verification/bfiu_properties.sv */
`timescale 1ns/1ps
`include "bfiu_map.vh"
module bfiu_properties (
  // Clock and reset.
  input logic ref_clk,
  input logic rst,
  // Write channels.
  input logic [3:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  // Read answer and live flags.
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [7:0] statusFlags
);
  // A control write whose address and data are taken on one edge.
  logic cw;
  logic [4:0] op;
  logic [7:0] f;
  assign cw = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && s_axi_awaddr == `BFIU_CTRL_OFS;
  assign op = s_axi_wdata[4:0];
  assign f = statusFlags;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Answers stand until taken; flags follow each control write.
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid) else $error("read data dropped");
  flags_reset_a: assert property ($fell(rst) |-> f == 8'h00)
    else $error("flags not clear after reset");
  flag_set_a:
    assert property (cw && op == `BFIU_OP_FSET |-> ##3
      f == ($past(f) | 8'h01 << $past(s_axi_wdata[7:5], 3)))
      else $error("flag set wrong");
  flag_clear_a:
    assert property (cw && op == `BFIU_OP_FCLR |-> ##3
      f == ($past(f) & ~(8'h01 << $past(s_axi_wdata[7:5], 3))))
      else $error("flag clear wrong");
  flags_kept_a:
    assert property (cw && op inside {`BFIU_OP_SWAP, `BFIU_OP_IOSET,
      `BFIU_OP_IOCLR, `BFIU_OP_TRANSFER_FLAG_TO_BIT} |-> ##3 $stable(f))
      else $error("flags changed");
  bit_store_a:
    assert property (cw && op == `BFIU_OP_BIT_TO_TRANSFER_FLAG |-> ##3
      (f & 8'hbf) == ($past(f) & 8'hbf)) else $error("bit store flags");
  shift_keep_a:
    assert property (cw && op inside {`BFIU_OP_ROTATE_LEFT_CARRY,
      `BFIU_OP_ROTATE_RIGHT_CARRY, `BFIU_OP_ARITH_SHIFT_RIGHT}
      |-> ##3 f[7:6] == $past(f[7:6]))
      else $error("shift touched T or I");
  // Main scenarios reached.
  cover property (cw && op == `BFIU_OP_FCLR);
  cover property (cw && op == `BFIU_OP_ROTATE_LEFT_CARRY);
  cover property (cw && op == `BFIU_OP_BIT_TO_TRANSFER_FLAG);
endmodule // bfiu_properties
bind bfiu_top bfiu_properties chk (.ref_clk, .rst, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
  .s_axi_rready, .statusFlags);

/* verification/tb_top.sv */
`timescale 1ns/1ps
`include "bfiu_map.vh"
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rResp;
  logic [7:0] statusFlags;
  int fails = 0, n_tests = 0;
  // Device under test and its 125 MHz clock.
  bfiu_top uut (.*);
  always #4 ref_clk = ~ref_clk;
  // Compare one value and count it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // A wait that ran out counts as a mismatch and ends the run.
  task automatic bound(input int n);
    if (n == 50) begin
      fails++;
      test_done();
    end
  endtask
  // Write one word; address and data are offered together.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    bound(n);
  endtask
  // Read one word into rd and rResp.
  task automatic rdReg(input logic [3:0] a);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rd = s_axi_rdata;
    rResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    bound(n);
  endtask
  // Load the operand, issue one operation and read its result.
  task automatic run(input logic [4:0] op, input logic [2:0] b,
      input logic [7:0] v);
    wr(`BFIU_OPERAND_OFS, {24'h0, v});
    wr(`BFIU_CTRL_OFS, {24'h0, b, op});
    rdReg(`BFIU_RESULT_OFS);
  endtask
  // Flags and result come out of reset clear.
  task automatic testReset();
    rdReg(`BFIU_FLAGS_OFS);
    chk(rd, 32'h0);
    rdReg(`BFIU_RESULT_OFS);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask
  // Set every flag in turn, then clear each; only that flag moves.
  task automatic testFlags();
    logic [31:0] e;
    e = 32'h0;
    for (int i = 0; i < 16; i++) begin
      wr(`BFIU_CTRL_OFS, {24'h0, i[2:0],
        i < 8 ? `BFIU_OP_FSET : `BFIU_OP_FCLR});
      e[i[2:0]] = i < 8;
      @(negedge ref_clk);
      chk({24'h0, statusFlags}, e);
    end
    $display("flag test done");
  endtask
  // Rotations through a set carry.
  task automatic testShift();
    wr(`BFIU_FLAGS_OFS, 32'h01);
    run(`BFIU_OP_ROTATE_LEFT_CARRY, 3'h0, 8'h81);
    chk(rd, 32'h03);
    chk({24'h0, statusFlags}, 32'h19);
    run(`BFIU_OP_ROTATE_RIGHT_CARRY, 3'h0, 8'h81);
    chk(rd, 32'hc0);
    chk({24'h0, statusFlags}, 32'h15);
    $display("shift test done");
  endtask
  // Bit operations, read-only result and an unmapped address.
  task automatic testBits();
    run(`BFIU_OP_ARITH_SHIFT_RIGHT, 3'h0, 8'h84);
    chk(rd, 32'hc2);
    run(`BFIU_OP_SWAP, 3'h0, 8'h5a);
    chk(rd, 32'ha5);
    run(`BFIU_OP_IOSET, 3'h2, 8'h00);
    chk(rd, 32'h04);
    run(`BFIU_OP_IOCLR, 3'h7, 8'hff);
    chk(rd, 32'h7f);
    wr(`BFIU_FLAGS_OFS, 32'h0);
    run(`BFIU_OP_BIT_TO_TRANSFER_FLAG, 3'h3, 8'h08);
    chk({24'h0, statusFlags}, 32'h40);
    run(`BFIU_OP_TRANSFER_FLAG_TO_BIT, 3'h0, 8'h00);
    chk(rd, 32'h01);
    chk({24'h0, statusFlags}, 32'h40);
    wr(`BFIU_RESULT_OFS, 32'hee);
    rdReg(`BFIU_RESULT_OFS);
    chk(rd, 32'h01);
    rdReg(4'h6);
    chk({30'h0, rResp}, 32'h2);
    $display("bit test done");
  endtask
  // Hold reset for four cycles, then run every scenario.
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    testReset();
    testFlags();
    testShift();
    testBits();
    test_done();
  end
endmodule // tb_top
